// ==== hdl/scc_params.svh ====
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes inclusion by its bare name from the scc_core design module.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// Register word indices; with the 8-bit data port the bus address is the index itself
`define SCC_IDX_INTCTL 8'h0b
`define SCC_IDX_PIRF 8'h0c
`define SCC_IDX_RESULT 8'h1e
`define SCC_IDX_CTLA 8'h1f
`define SCC_IDX_PIEN 8'h8c
`define SCC_IDX_ANALOG_PIN_SELECT_REG 8'h9d
`define SCC_IDX_CTLB 8'h9f
`define SCC_IDX_SYS 8'hf0

// Field positions
`define SCC_B_GIE 7
`define SCC_B_PERIPHERAL_IRQ_ENABLE 6
`define SCC_B_DONE 6
`define SCC_B_GO 2
`define SCC_B_PON 0
`define SCC_B_SLEEP 0

// Reset values and write masks
`define SCC_RST_INTCTL 8'h00
`define SCC_RST_PIRF 8'h00
`define SCC_RST_CTLA 8'h00
`define SCC_RST_PIEN 8'h00
`define SCC_RST_ANALOG_PIN_SELECT_REG 8'hff
`define SCC_RST_CTLB 8'h00
`define SCC_MASK_PIRF 8'hf1
`define SCC_MASK_PIEN 8'hf1
`define SCC_MASK_CTLB 8'h30

// Clock select codes and divisors
`define SCC_CS_RC 2'h3
`define SCC_DIV_OSC2 2
`define SCC_DIV_OSC8 8
`define SCC_DIV_OSC32 32

// Bit periods: sample phase is 1.5, eight bits, then load; 9.5 in all
`define SCC_HALF_PERIODS_ACQ 3
`define SCC_NBITS 8
`define SCC_ABORT_PERIODS 2
`define SCC_START_DELAY_CYC 4

`endif

// ==== hdl/scc_pkg.sv ====
// Types shared by the converter control block.
// Assumes scc_params.svh sits on the include path.
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_DELAY,
    SCC_ACQ,
    SCC_BITS,
    SCC_WAIT
  } scc_state_t;
endpackage

// ==== hdl/scc_rc_clock.sv ====
// Free-running stand-in for the converter's own RC oscillator: a half-period strobe.
// Assumes the enable comes from same-clock logic; runs in sleep because it ignores the core gate.
module scc_rc_clock #(
  parameter int HALF_CYC = 250
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  output logic tick_out
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run_in) begin
      cnt_d = 16'h0000;
    end else if (cnt_q == 16'(HALF_CYC - 1)) begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule // scc_rc_clock

// ==== hdl/scc_core.sv ====
// Converter control: registers over classic Wishbone, conversion sequencer, sleep handling.
// Assumes a comparator front end whose verdict is a pin; core sleep and reset come from the core.
// Contract
// [R1] Acquisition length does not depend on how many result bits are kept.
// [R2] Clock select may change mid-conversion; remaining bits use the new period.
// [R3] Bits resolved after a mid-conversion clock change are marked invalid.
// [R4] Software only switches among the three oscillator divisors mid-conversion.
// [R5] Time is 2 periods, N periods, then (8-N) short double-oscillator periods.
// [R6] Software times the clock switch itself; no signal marks the moment.
// [R7] Conversion survives sleep only with the RC clock selected.
// [R8] With RC selected, start waits one instruction cycle after go.
// [R9] Completion under RC clears go and loads the result.
// [R10] Completion in sleep with interrupt enabled wakes the device.
// [R11] Completion in sleep without interrupt powers converter down, power bit stays.
// [R12] Sleep with non-RC clock aborts conversion and powers down, power bit stays.
// [R13] Software sets go then sleeps immediately to convert during sleep.
// [R14] Software keeps the oscillator bit period within preferred limits.
// [R15] Reset restores registers, powers down and aborts conversion.
// [R16] Result register is not reset.
// [R17] Go starts; completion clears go, sets done, interrupt if all enables set.
// [R18] Clearing go aborts without result update; 2-period wait, then acquisition.
// [R19] Select codes 0..3 choose osc/2, osc/8, osc/32 and RC.
// [R20] A full conversion takes nine and a half bit periods.
// [R21] The RC clock runs independently of the core clock gate.
//
// Design decision made here: the Wishbone slave port.
`include "scc_params.svh"
module scc_core import scc_pkg::*; #(
  parameter int RC_HALF_CYC = 250
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [7:0] WB_DAT_IN,
  input wire logic WB_WE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_SEL_IN,
  input wire logic CMP_IN,
  input wire logic SLEEP_IN,
  output logic [7:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic SAMPLE_OUT,
  output logic ANALOG_ON_OUT,
  output logic [3:0] CHANNEL_OUT,
  output logic [7:0] TRIAL_OUT,
  output logic WAKE_OUT,
  output logic IRQ_OUT
);
  // Pin inputs pass two flops; the first flop is read only by the second
  logic cmp_m_q, cmp_s_q, slp_m_q, slp_s_q;
  always_ff @(posedge CLK_IN) begin
    cmp_m_q <= CMP_IN;
    cmp_s_q <= cmp_m_q;
    slp_m_q <= SLEEP_IN;
    slp_s_q <= slp_m_q;
  end

  logic [7:0] intctl_q, intctl_d, pirf_q, pirf_d, ctla_q, ctla_d;
  logic [7:0] pien_q, pien_d, analog_pin_select_reg_q, analog_pin_select_reg_d, ctlb_q, ctlb_d;
  logic [7:0] result_q, result_d, sar_q, sar_d, invalid_q, invalid_d;
  logic [7:0] rdat_q, rdat_d;
  logic ack_q, ack_d, off_q, off_d, wake_q, wake_d, irq_q, irq_d;
  logic [6:0] tick_cnt_q, tick_cnt_d;
  logic [3:0] hcnt_q, hcnt_d;
  logic [2:0] bit_q, bit_d;
  logic [2:0] dly_q, dly_d;
  logic [1:0] cs_run_q, cs_run_d;
  scc_state_t st_q, st_d;

  logic rc_tick;
  logic osc_tick;
  logic half_tick;
  logic wr_go;
  logic [1:0] cs;
  logic rc_sel;

  assign cs = ctla_q[7:6];
  assign rc_sel = (cs == `SCC_CS_RC);

  function automatic logic [6:0] half_div(input logic [1:0] sel);
    unique case (sel)
      2'h0: half_div = 7'(`SCC_DIV_OSC2 / 2);
      2'h1: half_div = 7'(`SCC_DIV_OSC8 / 2);
      default: half_div = 7'(`SCC_DIV_OSC32 / 2);
    endcase
  endfunction

  // RC oscillator keeps time regardless of core sleep
  scc_rc_clock #(.HALF_CYC(RC_HALF_CYC)) u_rc ( // R21
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .run_in(ctla_q[`SCC_B_PON] && rc_sel),
    .tick_out(rc_tick)
  );

  // Divider follows the live select so a switch takes effect at once
  assign osc_tick = (tick_cnt_q + 7'h01 >= half_div(cs)); // R2 R19
  assign half_tick = rc_sel ? rc_tick : osc_tick;

  logic bus_req;
  logic [7:0] idx;
  assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign idx = WB_ADR_IN;
  assign wr_go = bus_req && WB_WE_IN && WB_SEL_IN && (idx == `SCC_IDX_CTLA);

  always_comb begin
    intctl_d = intctl_q;
    pirf_d = pirf_q;
    ctla_d = ctla_q;
    pien_d = pien_q;
    analog_pin_select_reg_d = analog_pin_select_reg_q;
    ctlb_d = ctlb_q;
    result_d = result_q;
    sar_d = sar_q;
    invalid_d = invalid_q;
    st_d = st_q;
    off_d = off_q;
    hcnt_d = hcnt_q;
    bit_d = bit_q;
    dly_d = dly_q;
    cs_run_d = cs_run_q;
    tick_cnt_d = osc_tick ? 7'h00 : tick_cnt_q + 7'h01;
    ack_d = bus_req;
    rdat_d = 8'h00;
    wake_d = 1'b0;
    if (bus_req && !WB_WE_IN) begin
      unique case (idx)
        `SCC_IDX_INTCTL: rdat_d = intctl_q;
        `SCC_IDX_PIRF: rdat_d = pirf_q;
        `SCC_IDX_RESULT: rdat_d = result_q;
        `SCC_IDX_CTLA: rdat_d = ctla_q;
        `SCC_IDX_PIEN: rdat_d = pien_q;
        `SCC_IDX_ANALOG_PIN_SELECT_REG: rdat_d = analog_pin_select_reg_q;
        `SCC_IDX_CTLB: rdat_d = ctlb_q;
        `SCC_IDX_SYS: rdat_d = {invalid_q[7:1], off_q};
        default: rdat_d = 8'h00;
      endcase
    end
    if (bus_req && WB_WE_IN && WB_SEL_IN) begin
      unique case (idx)
        `SCC_IDX_INTCTL: intctl_d = WB_DAT_IN;
        `SCC_IDX_PIRF: pirf_d = WB_DAT_IN & `SCC_MASK_PIRF;
        `SCC_IDX_RESULT: result_d = WB_DAT_IN;
        `SCC_IDX_CTLA: ctla_d = WB_DAT_IN;
        `SCC_IDX_PIEN: pien_d = WB_DAT_IN & `SCC_MASK_PIEN;
        `SCC_IDX_ANALOG_PIN_SELECT_REG: analog_pin_select_reg_d = WB_DAT_IN;
        `SCC_IDX_CTLB: ctlb_d = WB_DAT_IN & `SCC_MASK_CTLB;
        default: ;
      endcase
    end
    if (!ctla_q[`SCC_B_PON] || !slp_s_q) begin
      off_d = 1'b0;
    end
    unique case (st_q)
      SCC_IDLE: begin
        if (wr_go && WB_DAT_IN[`SCC_B_GO] && WB_DAT_IN[`SCC_B_PON]) begin
          // One instruction cycle of grace under RC lets sleep go first
          dly_d = rc_sel ? 3'(`SCC_START_DELAY_CYC) : 3'h0; // R8
          st_d = SCC_DELAY;
          off_d = 1'b0;
        end
      end
      SCC_DELAY: begin
        if (dly_q == 3'h0) begin
          st_d = SCC_ACQ;
          hcnt_d = 4'h0;
          cs_run_d = cs;
          invalid_d = 8'h00;
        end else begin
          dly_d = dly_q - 3'h1;
        end
      end
      SCC_ACQ: begin
        // Same sampling span whatever resolution is kept
        if (half_tick) begin // R1
          if (hcnt_q == 4'(`SCC_HALF_PERIODS_ACQ - 1)) begin
            st_d = SCC_BITS;
            hcnt_d = 4'h0;
            bit_d = 3'(`SCC_NBITS - 1);
            sar_d = 8'h80;
          end else begin
            hcnt_d = hcnt_q + 4'h1;
          end
        end
      end
      SCC_BITS: begin
        // Two half ticks per bit period; eight bits then load: 9.5 total
        if (half_tick) begin // R20 R5
          if (hcnt_q == 4'h1) begin
            hcnt_d = 4'h0;
            if (cs != cs_run_q) begin
              invalid_d[bit_q] = 1'b1; // R3
            end
            sar_d[bit_q] = cmp_s_q;
            if (bit_q != 3'h0) begin
              sar_d[bit_q - 3'h1] = 1'b1;
              bit_d = bit_q - 3'h1;
            end else begin
              result_d = {sar_q[7:1], cmp_s_q}; // R9
              ctla_d[`SCC_B_GO] = 1'b0; // R17
              pirf_d[`SCC_B_DONE] = 1'b1; // R17
              st_d = SCC_IDLE;
              if (slp_s_q && pien_q[`SCC_B_DONE]) begin
                wake_d = 1'b1; // R10
              end else if (slp_s_q) begin
                off_d = 1'b1; // R11
              end
            end
          end else begin
            hcnt_d = hcnt_q + 4'h1;
          end
        end
      end
      SCC_WAIT: begin
        if (half_tick) begin // R18
          if (hcnt_q == 4'(2 * `SCC_ABORT_PERIODS - 1)) begin
            st_d = SCC_IDLE;
          end else begin
            hcnt_d = hcnt_q + 4'h1;
          end
        end
      end
    endcase
    if (st_q != SCC_IDLE && st_q != SCC_WAIT) begin
      if (slp_s_q && !rc_sel) begin
        st_d = SCC_IDLE; // R12 R7
        off_d = 1'b1;
        ctla_d[`SCC_B_GO] = 1'b0;
      end else if (!ctla_q[`SCC_B_GO] || !ctla_q[`SCC_B_PON]) begin
        st_d = SCC_WAIT; // R18
        hcnt_d = 4'h0;
      end
    end
  end

  assign irq_d = pirf_q[`SCC_B_DONE] && pien_q[`SCC_B_DONE] && intctl_q[`SCC_B_PERIPHERAL_IRQ_ENABLE]
    && intctl_q[`SCC_B_GIE]; // R17

  // Result and trial word hold across resets; only data path
  always_ff @(posedge CLK_IN) begin
    result_q <= result_d; // R16
    sar_q <= sar_d;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin // R15
      intctl_q <= `SCC_RST_INTCTL;
      pirf_q <= `SCC_RST_PIRF;
      ctla_q <= `SCC_RST_CTLA;
      pien_q <= `SCC_RST_PIEN;
      analog_pin_select_reg_q <= `SCC_RST_ANALOG_PIN_SELECT_REG;
      ctlb_q <= `SCC_RST_CTLB;
      invalid_q <= 8'h00;
      rdat_q <= 8'h00;
      ack_q <= 1'b0;
      off_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
      tick_cnt_q <= 7'h00;
      hcnt_q <= 4'h0;
      bit_q <= 3'h0;
      dly_q <= 3'h0;
      cs_run_q <= 2'h0;
      st_q <= SCC_IDLE;
    end else begin
      intctl_q <= intctl_d;
      pirf_q <= pirf_d;
      ctla_q <= ctla_d;
      pien_q <= pien_d;
      analog_pin_select_reg_q <= analog_pin_select_reg_d;
      ctlb_q <= ctlb_d;
      invalid_q <= invalid_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
      off_q <= off_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
      tick_cnt_q <= tick_cnt_d;
      hcnt_q <= hcnt_d;
      bit_q <= bit_d;
      dly_q <= dly_d;
      cs_run_q <= cs_run_d;
      st_q <= st_d;
    end
  end

  logic samp_q, on_q;
  logic [3:0] ch_q;
  logic [7:0] trial_q;
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      samp_q <= 1'b0;
      on_q <= 1'b0;
      ch_q <= 4'h0;
      trial_q <= 8'h00;
    end else begin
      samp_q <= (st_d == SCC_ACQ) || (st_d == SCC_IDLE && ctla_d[`SCC_B_PON] && !off_d);
      on_q <= ctla_d[`SCC_B_PON] && !off_d; // R11 R12
      ch_q <= {ctla_d[1], ctla_d[5:3]};
      trial_q <= sar_d;
    end
  end

  assign WB_DAT_OUT = rdat_q;
  assign WB_ACK_OUT = ack_q;
  assign SAMPLE_OUT = samp_q;
  assign ANALOG_ON_OUT = on_q;
  assign CHANNEL_OUT = ch_q;
  assign TRIAL_OUT = trial_q;
  assign WAKE_OUT = wake_q;
  assign IRQ_OUT = irq_q;

  chk_ack_one_cycle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held two cycles");
  chk_done_clears_go: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R17
    $rose(pirf_q[`SCC_B_DONE]) && st_q == SCC_IDLE |-> !ctla_q[`SCC_B_GO])
    else $error("done set while go still high");
  chk_irq_gating: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R17
    IRQ_OUT |-> $past(pien_q[`SCC_B_DONE]) && $past(intctl_q[`SCC_B_GIE]))
    else $error("interrupt without enables");
  chk_sleep_abort: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R12
    (st_q == SCC_BITS && slp_s_q && !rc_sel) |=> st_q == SCC_IDLE && off_q)
    else $error("sleep did not abort");
  chk_power_bit_kept: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R11
    $rose(off_q) |-> ctla_q[`SCC_B_PON]) else $error("power bit lost on power down");
  chk_rc_start_delay: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R8
    (st_q == SCC_IDLE && st_d == SCC_DELAY && rc_sel) |=> st_q == SCC_DELAY [*5])
    else $error("rc start too early");
  chk_abort_keeps_res: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R18
    (st_q == SCC_WAIT) |=> $stable(result_q) || $past(WB_WE_IN))
    else $error("abort changed result");
  chk_wake_needs_en: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // R10
    WAKE_OUT |-> pien_q[`SCC_B_DONE] && pirf_q[`SCC_B_DONE])
    else $error("wake without enable");
endmodule // scc_core

// ==== testbench/scc_cmp_model.sv ====
// Comparator and sample-and-hold stand-in for the converter's analog front end.
// Assumes the level is steady while sampling; the verdict is noise while powered down.
module scc_cmp_model (
  input wire logic clk_in,
  input wire logic sample_in,
  input wire logic on_in,
  input wire logic [7:0] trial_in,
  input wire logic [7:0] level_in,
  output logic cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held_q = 8'h00;
  logic flip_q = 1'b0;
  always_ff @(posedge clk_in) begin
    if (sample_in) held_q <= level_in;
    flip_q <= ~flip_q;
  end
  // Level sits half a step above its code, so an equal trial reads as below it
  assign cmp_out = on_in ? (trial_in <= held_q) : flip_q;
endmodule // scc_cmp_model

// ==== testbench/scc_core_tb.sv ====
// Self-checking bench for the converter control block: bus tasks and scenario tasks.
// Assumes the comparator model answers the trial word; RC half period shortened to 3.
module scc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, we = 0, cyc = 0, stb = 0, sel = 1, slp = 0;
  logic [7:0] adr = 8'h00, wdat = 8'h00, lvl = 8'h00, rdat, trial, q;
  logic cmp, ack, smp, aon, wake, irq;
  logic [3:0] chan;
  int fail_count = 0, comparisons = 0, cyc_n = 0, wakes = 0;
  scc_core #(.RC_HALF_CYC(3)) scc_core_i (.CLK_IN(clk), .RESETN_IN(rstn), .WB_ADR_IN(adr),
    .WB_DAT_IN(wdat), .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_SEL_IN(sel),
    .CMP_IN(cmp), .SLEEP_IN(slp), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SAMPLE_OUT(smp),
    .ANALOG_ON_OUT(aon), .CHANNEL_OUT(chan), .TRIAL_OUT(trial), .WAKE_OUT(wake),
    .IRQ_OUT(irq));
  scc_cmp_model scc_cmp_model_i (.clk_in(clk), .sample_in(smp), .on_in(aon),
    .trial_in(trial), .level_in(lvl), .cmp_out(cmp));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cyc_n == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // Request holds until the rising edge that samples ack high; data is taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_go();
    do wb(0, 8'h1f, 8'h00); while (q[2] === 1'b1);
  endtask
  task automatic t_reset();
    logic [7:0] idx [6] = '{8'h0b, 8'h0c, 8'h1f, 8'h8c, 8'h9d, 8'h9f};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    foreach (idx[i]) begin
      wb(0, idx[i], 8'h00);
      chk("reset value", rv[i], q);
    end
    wb(1, 8'h55, 8'h12);
    wb(0, 8'h55, 8'h00);
    chk("unmapped", 8'h00, q);
    wb(1, 8'h1f, 8'h1b);
    @(negedge clk);
    chk("channel", 8'h0b, {4'h0, chan});
    @(posedge clk);
  endtask
  task automatic t_osc();
    // Divide by two lies below the minimum bit period; only a full-scale level converts cleanly
    logic [7:0] lv [3] = '{8'hff, 8'h5a, 8'ha5};
    int t0, h;
    wb(1, 8'h8c, 8'h40);
    for (int cs = 0; cs < 3; cs++) begin
      h = (cs == 0) ? 1 : (cs == 1) ? 4 : 16;
      lvl <= lv[cs];
      wb(1, 8'h0b, (cs == 2) ? 8'h40 : 8'hc0);
      wb(1, 8'h1f, {cs[1:0], 6'h01});
      wb(1, 8'h1f, {cs[1:0], 6'h05});
      t0 = cyc_n;
      wait_go();
      chk("duration", 8'h01, 8'((cyc_n - t0 >= 19 * h - 2) && (cyc_n - t0 <= 19 * h + 24)));
      wb(0, 8'h1e, 8'h00);
      chk("result", lv[cs], q);
      wb(0, 8'h0c, 8'h00);
      chk("done flag", 8'h40, q & 8'h40);
      chk("irq", (cs == 2) ? 8'h00 : 8'h01, {7'h0, irq});
      wb(1, 8'h0c, 8'h00);
    end
  endtask
  task automatic t_switch();
    int t0;
    lvl <= 8'hc3;
    wb(1, 8'h1f, 8'h81);
    wb(1, 8'h1f, 8'h85);
    // Bit 7 resolves near cycle 84 at the slow rate, bit 6 not before 116
    repeat (96) @(posedge clk);
    wb(1, 8'h1f, 8'h05);
    t0 = cyc_n;
    wait_go();
    chk("fast finish", 8'h01, 8'(cyc_n - t0 <= 40));
    wb(0, 8'h1e, 8'h00);
    chk("kept msb", 8'h80, q & 8'h80);
    wb(0, 8'hf0, 8'h00);
    chk("invalid marks", 8'h7e, q);
    wb(1, 8'h0c, 8'h00);
  endtask
  task automatic t_abort();
    logic [7:0] keep;
    wb(0, 8'h1e, 8'h00);
    keep = q;
    lvl <= 8'h3c;
    wb(1, 8'h1f, 8'h85);
    wb(1, 8'h1f, 8'h81);
    repeat (200) @(posedge clk);
    wb(0, 8'h1e, 8'h00);
    chk("result kept", keep, q);
    wb(0, 8'h0c, 8'h00);
    chk("no done", 8'h00, q & 8'h40);
    @(negedge clk);
    chk("resampling", 8'h01, {7'h0, smp});
    @(posedge clk);
  endtask
  task automatic t_sleep_osc();
    logic [7:0] keep;
    wb(0, 8'h1e, 8'h00);
    keep = q;
    lvl <= 8'h77;
    wb(1, 8'h1f, 8'h85);
    slp <= 1'b1;
    repeat (20) @(posedge clk);
    wb(0, 8'hf0, 8'h00);
    chk("powered down", 8'h01, q & 8'h01);
    chk("analog off", 8'h00, {7'h0, aon});
    wb(0, 8'h1e, 8'h00);
    chk("result kept", keep, q);
    slp <= 1'b0;
    wb(0, 8'h1f, 8'h00);
    chk("power bit", 8'h01, q & 8'h01);
    wb(1, 8'h1f, 8'h81);
    repeat (200) @(posedge clk);
  endtask
  task automatic t_sleep_rc(input logic en, input logic [7:0] lv);
    int w0;
    lvl <= lv;
    wb(1, 8'h8c, {1'b0, en, 6'h00});
    wb(1, 8'h1f, 8'hc1);
    w0 = wakes;
    wb(1, 8'h1f, 8'hc5);
    slp <= 1'b1;
    repeat (150) @(posedge clk);
    chk("wake count", {7'h0, en}, 8'(wakes - w0));
    chk("analog on", {7'h0, en}, {7'h0, aon});
    slp <= 1'b0;
    wb(0, 8'h1e, 8'h00);
    chk("sleep result", lv, q);
    wb(0, 8'h1f, 8'h00);
    chk("go and power", 8'h01, q & 8'h05);
    wb(1, 8'h0c, 8'h00);
  endtask
  task automatic t_midreset();
    wb(1, 8'h1f, 8'h81);
    wb(1, 8'h1f, 8'h85);
    repeat (50) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wb(0, 8'h1f, 8'h00);
    chk("control cleared", 8'h00, q);
    chk("analog off", 8'h00, {7'h0, aon});
    wb(0, 8'h1e, 8'h00);
    chk("result survives", 8'h81, q);
    wb(1, 8'h1e, 8'h5a);
    wb(0, 8'h1e, 8'h00);
    chk("result write", 8'h5a, q);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_osc();
    t_switch();
    t_abort();
    t_sleep_osc();
    t_sleep_rc(1'b1, 8'h00);
    t_sleep_rc(1'b0, 8'h81);
    t_midreset();
    report_and_stop();
  end
endmodule // scc_core_tb
